// File: verif/bus_master_model.sv
module bus_master_model (
  // Clock and resolved data wire
  input wire logic mclk,
  input wire logic sda_line,
  // Bus lines driven by the master
  output logic scl,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  // Extra low time per bit, so that a slow master can be played.
  int extra = 0;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic q();
    repeat (2) @(posedge mclk);
  endtask : q

  // The clock only moves inside frames and rests high between them.
  task automatic bit_io(input logic b, output logic r);
    q();
    repeat (extra) @(posedge mclk);
    sda_pull <= ~b;
    q();
    scl <= 1'b1;
    q();
    @(posedge mclk);
    @(negedge mclk);
    r = sda_line;
    @(posedge mclk);
    scl <= 1'b0;
  endtask : bit_io

  // Data is released a full half period before the clock rises, so the slave's late ACK release is never a stop.
  task automatic start();
    q();
    sda_pull <= 1'b0;
    q();
    q();
    scl <= 1'b1;
    q();
    q();
    sda_pull <= 1'b1;
    q();
    q();
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    q();
    sda_pull <= 1'b1;
    q();
    q();
    scl <= 1'b1;
    q();
    q();
    sda_pull <= 1'b0;
    q();
  endtask : stop

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : send

  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : recv

  task automatic probe(input logic [6:0] dev, output logic ok);
    start();
    send({dev, 1'b0}, ok);
    stop();
  endtask : probe

  task automatic write_reg(input logic [6:0] dev, input logic [2:0] ptr, input int n, input logic [15:0] val,
                           output logic ok);
    logic a0;
    logic a1;
    start();
    send({dev, 1'b0}, a0);
    send({5'h00, ptr}, a1);
    ok = a0 & a1;
    if (n == 2) begin
      send(val[15:8], a1);
      ok = ok & a1;
    end
    send(val[7:0], a1);
    ok = ok & a1;
    stop();
  endtask : write_reg

  task automatic read_reg(input logic [6:0] dev, input logic [2:0] ptr, input logic setp, input int n,
                          output logic [15:0] val, output logic ok);
    logic a0;
    logic a1;
    ok = 1'b1;
    val = 16'h0000;
    if (setp) begin
      start();
      send({dev, 1'b0}, a0);
      send({5'h00, ptr}, a1);
      ok = a0 & a1;
    end
    start();
    send({dev, 1'b1}, a0);
    ok = ok & a0;
    if (n == 2) begin
      recv(1'b0, val[15:8]);
    end
    recv(1'b1, val[7:0]);
    stop();
  endtask : read_reg
endmodule : bus_master_model

// File: verif/temp_window_comparator_tb.sv
module temp_window_comparator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CONV = 400;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic addr_b0 = 1'b1;
  logic addr_b1 = 1'b0;
  logic [12:0] temp = 13'h0100;
  logic scl, sda_pull, sda_oe, sda_out, sda_line, conv_done;
  logic alert_out, alert_oe, critical_flag_out, critical_flag_oe, shut, alert_pin, critical_flag_pin, ok;
  logic [6:0] dev = 7'h49;
  logic [15:0] v;
  int fails = 0;
  int samples_checked = 0;
  int conv_seen = 0;
  int k;

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (conv_done === 1'b1) conv_seen <= conv_seen + 1;
  // Every open-drain line has an external pull-up; SCL is driven directly by the master.
  assign sda_line = sda_oe ? sda_out : (sda_pull ? 1'b0 : 1'b1);
  assign alert_pin = alert_oe ? alert_out : 1'b1;
  assign critical_flag_pin = critical_flag_oe ? critical_flag_out : 1'b1;

  temp_window_comparator #(.CONV_CYCLES(CONV)) dut (.MCLK(mclk), .ARST_N(arst_n), .SCL(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SELECT_BIT0(addr_b0), .ADDR_SELECT_BIT1(addr_b1),
    .TEMP_SAMPLE(temp), .CONV_DONE(conv_done), .ALERT_OUT(alert_out), .ALERT_OE(alert_oe),
    .CRITICAL_ALARM_OUT(critical_flag_out), .CRITICAL_ALARM_OE(critical_flag_oe), .SHUTDOWN_ACTIVE(shut));
  bus_master_model m (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic pins(input logic a, input logic c);
    check({14'h0, alert_pin, critical_flag_pin}, {14'h0, a, c}, "alert and alarm pins");
  endtask : pins

  task automatic wait_conv(input int n);
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(negedge mclk);
        k++;
      end while (conv_done !== 1'b1 && k < 3 * CONV);
      if (k >= 3 * CONV) begin
        check(16'h0, 16'h1, "conversion timeout");
        conclude();
      end
    end
    repeat (3) @(posedge mclk);
  endtask : wait_conv

  // The new value is applied right after a completion, so each of the n conversions samples it.
  task automatic set_temp(input logic [12:0] t, input int n);
    wait_conv(1);
    temp <= t;
    wait_conv(n);
  endtask : set_temp

  task automatic wr(input logic [2:0] ptr, input int n, input logic [15:0] val);
    m.write_reg(dev, ptr, n, val, ok);
    check({15'h0, ok}, 16'h1, "write acknowledge");
  endtask : wr

  task automatic rd(input logic [2:0] ptr, input int n, input logic [15:0] exp);
    m.read_reg(dev, ptr, 1'b1, n, v, ok);
    check({15'h0, ok}, 16'h1, "read acknowledge");
    check(v, exp, "read data");
  endtask : rd

  task automatic clr();
    m.read_reg(dev, temp_window_pkg::PTR_TEMP, 1'b1, 2, v, ok);
  endtask : clr

  task automatic s_defaults();
    pins(1'b1, 1'b1);
    check({15'h0, shut}, 16'h0, "shutdown flag");
    rd(temp_window_pkg::PTR_CONFIG, 1, 16'h0000);
    rd(temp_window_pkg::PTR_HYSTERESIS, 2, 16'h0100);
    rd(temp_window_pkg::PTR_CRITICAL, 2, 16'h2800);
    rd(temp_window_pkg::PTR_LOW, 2, 16'h0500);
    rd(temp_window_pkg::PTR_HIGH, 2, 16'h2000);
  endtask : s_defaults

  task automatic s_addr();
    m.extra = 6;
    for (int s = 0; s < 4; s++) begin
      addr_b0 <= s[0];
      addr_b1 <= s[1];
      repeat (5) @(posedge mclk);
      m.probe({5'b10010, s[1:0]}, ok);
      check({15'h0, ok}, 16'h1, "own address");
      m.probe({5'b10010, ~s[1], s[0]}, ok);
      check({15'h0, ok}, 16'h0, "strap mismatch");
      m.probe({5'b10110, s[1:0]}, ok);
      check({15'h0, ok}, 16'h0, "fixed bits mismatch");
    end
    addr_b0 <= 1'b1;
    addr_b1 <= 1'b0;
    m.extra = 0;
    repeat (5) @(posedge mclk);
  endtask : s_addr

  task automatic s_fast_reads();
    rd(temp_window_pkg::PTR_TEMP, 2, 16'h0800);
    wait_conv(1);
    temp <= 13'h0120;
    k = conv_seen;
    repeat (4) begin
      m.read_reg(dev, temp_window_pkg::PTR_TEMP, 1'b0, 2, v, ok);
      check(v, 16'h0800, "temperature during fast reads");
    end
    check(16'(conv_seen - k), 16'h0, "conversions during fast reads");
    wait_conv(1);
    rd(temp_window_pkg::PTR_TEMP, 2, 16'h0900);
  endtask : s_fast_reads

  task automatic s_comparator();
    set_temp(13'h1c90, 2);
    pins(1'b0, 1'b1);
    rd(temp_window_pkg::PTR_TEMP, 2, 16'he481);
    set_temp(13'h00b0, 2);
    pins(1'b0, 1'b1);
    rd(temp_window_pkg::PTR_TEMP, 2, 16'h0581);
    pins(1'b1, 1'b1);
    wait_conv(1);
    pins(1'b0, 1'b1);
    set_temp(13'h00d0, 2);
    pins(1'b1, 1'b1);
  endtask : s_comparator

  task automatic s_critical();
    set_temp(13'h0600, 2);
    pins(1'b0, 1'b0);
    rd(temp_window_pkg::PTR_TEMP, 2, 16'h3006);
    pins(1'b1, 1'b0);
    set_temp(13'h04f0, 2);
    pins(1'b0, 1'b0);
    set_temp(13'h04d0, 2);
    pins(1'b0, 1'b1);
    set_temp(13'h0100, 2);
    pins(1'b1, 1'b1);
  endtask : s_critical

  task automatic s_event();
    wr(temp_window_pkg::PTR_CONFIG, 1, 16'h0002);
    clr();
    set_temp(13'h0050, 2);
    pins(1'b0, 1'b1);
    clr();
    pins(1'b1, 1'b1);
    wait_conv(3);
    pins(1'b1, 1'b1);
    set_temp(13'h00d0, 2);
    pins(1'b0, 1'b1);
    clr();
    set_temp(13'h0450, 2);
    pins(1'b0, 1'b1);
    clr();
    set_temp(13'h0100, 2);
    pins(1'b0, 1'b1);
    clr();
    pins(1'b1, 1'b1);
    wr(temp_window_pkg::PTR_CONFIG, 1, 16'h0000);
  endtask : s_event

  task automatic s_fault();
    wr(temp_window_pkg::PTR_CONFIG, 1, 16'h0010);
    clr();
    set_temp(13'h0050, 3);
    pins(1'b1, 1'b1);
    wait_conv(1);
    pins(1'b0, 1'b1);
    set_temp(13'h0100, 1);
    pins(1'b1, 1'b1);
    wr(temp_window_pkg::PTR_CONFIG, 1, 16'h0000);
  endtask : s_fault

  task automatic s_shutdown();
    set_temp(13'h0600, 2);
    pins(1'b0, 1'b0);
    wr(temp_window_pkg::PTR_CONFIG, 1, 16'h0001);
    repeat (5) @(posedge mclk);
    check({15'h0, shut}, 16'h1, "shutdown flag");
    pins(1'b1, 1'b1);
    k = conv_seen;
    repeat (3 * CONV) @(posedge mclk);
    check(16'(conv_seen - k), 16'h0, "conversions in shutdown");
    wr(temp_window_pkg::PTR_LOW, 2, 16'h0400);
    rd(temp_window_pkg::PTR_LOW, 2, 16'h0400);
    rd(temp_window_pkg::PTR_CONFIG, 1, 16'h0001);
    wr(temp_window_pkg::PTR_LOW, 2, 16'h0500);
    wr(temp_window_pkg::PTR_CONFIG, 1, 16'h0000);
    wait_conv(1);
    check({15'h0, shut}, 16'h0, "shutdown flag");
    pins(1'b0, 1'b0);
    set_temp(13'h0100, 2);
    pins(1'b1, 1'b1);
    // Active-high polarity with nothing active must pull both pins low.
    wr(temp_window_pkg::PTR_CONFIG, 1, 16'h000c);
    repeat (3) @(posedge mclk);
    pins(1'b0, 1'b0);
    wr(temp_window_pkg::PTR_CONFIG, 1, 16'h0000);
    repeat (3) @(posedge mclk);
    pins(1'b1, 1'b1);
  endtask : s_shutdown

  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    s_defaults();
    s_addr();
    s_fast_reads();
    s_comparator();
    s_critical();
    s_event();
    s_fault();
    s_shutdown();
    conclude();
  end
endmodule : temp_window_comparator_tb

// File: verilog/temp_window_comparator.sv
// Function
// - Window alert outside band, alarm above critical.
// - Status flags change only from comparisons.
// - Critical output follows flag, reads ignored.
// - Any read restarts the conversion.
// - Comparator mode: read clears alert until conversion.
// - Low alert holds until above low plus hysteresis.
// - Event mode: alert set once, read clears.
// - Event: setpoint rise or hysteresis fall.
// - After low clear, rearm above low plus hysteresis.
// - Hysteresis adds to low, subtracts from others.
// - Power-up defaults for limits, mode, polarity, pointer.
// - Power-on reset restores all defaults.
// - Slave only; clock input, data bidirectional.
// - Address is 10010 plus two select pins.
// - Values are 13-bit two's complement words.
// - Temperature word: value high, flags low.
// - Frequent reads stop temperature updates.
// - Shutdown stops conversions and silences both outputs.
// - Bus and registers work during shutdown.
// - Shutdown may take effect later than written.
// - Both alert pins are open-drain.
// - Fault queue needs four consecutive faults.
// - Configuration bit four enables fault queue.
// - Configuration bit selects comparator or event mode.
module temp_window_comparator #(
  parameter int CONV_CYCLES = temp_window_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic ARST_N,
  // Two-wire serial bus
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Address select straps
  input wire logic ADDR_SELECT_BIT0,
  input wire logic ADDR_SELECT_BIT1,
  // Converter result and completion
  input wire logic [12:0] TEMP_SAMPLE,
  output logic CONV_DONE,
  // Open-drain alert pins
  output logic ALERT_OUT,
  output logic ALERT_OE,
  output logic CRITICAL_ALARM_OUT,
  output logic CRITICAL_ALARM_OE,
  // Status
  output logic SHUTDOWN_ACTIVE
);

  function automatic logic signed [13:0] ext(input logic [12:0] v);
    ext = {v[12], v};
  endfunction : ext
  function automatic logic [2:0] qnext(input logic [2:0] cnt, input logic cond);
    if (!cond) begin
      qnext = 3'h0;
    end else if (cnt >= temp_window_pkg::FAULT_QUEUE_DEPTH) begin
      qnext = temp_window_pkg::FAULT_QUEUE_DEPTH;
    end else begin
      qnext = cnt + 3'h1;
    end
  endfunction : qnext
  logic scl_meta_r, scl_s_r, scl_d_r, sda_meta_r, sda_s_r, sda_d_r;
  logic [1:0] asel_meta_r, asel_s_r;
  logic scl_rise, scl_fall, bus_start, bus_stop, addr_match;
  temp_window_pkg::bus_state_t state_r;
  logic [7:0] shift_r, msb_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [2:0] ptr_r;
  logic rw_r, nack_r, sda_drv_r, rd_evt, wr_byte;
  logic [15:0] rd_word_r, rd_mux;
  logic [4:0] cfg_r;
  logic [12:0] low_r, high_r, critical_r, hysteresis_r, temp_r;
  logic [31:0] conv_cnt_r;
  logic conv_run, conv_done, conv_done_r;
  logic signed [13:0] t_s, low_h, high_h, critical_h;
  logic [2:0] need, q_lo_r, q_hi_r, q_cr_r, q_lo_nxt, q_hi_nxt, q_cr_nxt;
  logic low_flag_r, high_flag_r, critical_flag_r;
  logic low_nxt, high_nxt, critical_nxt, window_event;
  logic alert_r, alert_oe_r, alarm_oe_r;

  // Bus pins and straps come from outside: two flops before any use.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_meta_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      asel_meta_r <= 2'h0;
      asel_s_r <= 2'h0;
    end else begin
      scl_meta_r <= SCL;
      scl_s_r <= scl_meta_r;
      scl_d_r <= scl_s_r;
      sda_meta_r <= SDA_IN;
      sda_s_r <= sda_meta_r;
      sda_d_r <= sda_s_r;
      asel_meta_r <= {ADDR_SELECT_BIT1, ADDR_SELECT_BIT0};
      asel_s_r <= asel_meta_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_d_r;
  assign scl_fall = ~scl_s_r & scl_d_r;
  assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign addr_match = (shift_r[7:1] == {temp_window_pkg::SLAVE_ADDR_HI, asel_s_r});
  assign rd_evt = (state_r == temp_window_pkg::S_ADDR) && scl_fall && (bit_cnt_r == 4'h8)
                  && addr_match && shift_r[0];
  assign wr_byte = (state_r == temp_window_pkg::S_WRITE) && scl_fall && (bit_cnt_r == 4'h8);

  always_comb begin
    case (ptr_r)
      temp_window_pkg::PTR_TEMP: rd_mux = {temp_r, critical_flag_r, high_flag_r, low_flag_r};
      temp_window_pkg::PTR_CONFIG: rd_mux = {3'h0, cfg_r, 3'h0, cfg_r};
      temp_window_pkg::PTR_HYSTERESIS: rd_mux = {hysteresis_r, 3'h0};
      temp_window_pkg::PTR_CRITICAL: rd_mux = {critical_r, 3'h0};
      temp_window_pkg::PTR_LOW: rd_mux = {low_r, 3'h0};
      temp_window_pkg::PTR_HIGH: rd_mux = {high_r, 3'h0};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Slave engine: samples on SCL rise, changes SDA only on SCL fall.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= temp_window_pkg::S_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      byte_cnt_r <= 2'h0;
      ptr_r <= temp_window_pkg::PTR_RESET;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sda_drv_r <= 1'b0;
      rd_word_r <= 16'h0000;
    end else if (bus_stop) begin
      state_r <= temp_window_pkg::S_IDLE;
      sda_drv_r <= 1'b0;
    end else if (bus_start) begin
      state_r <= temp_window_pkg::S_ADDR;
      bit_cnt_r <= 4'h0;
      byte_cnt_r <= 2'h0;
      sda_drv_r <= 1'b0;
    end else begin
      case (state_r)
        temp_window_pkg::S_ADDR, temp_window_pkg::S_WRITE: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            if (state_r == temp_window_pkg::S_WRITE) begin
              sda_drv_r <= 1'b1;
              state_r <= temp_window_pkg::S_ACK;
              if (byte_cnt_r == 2'h0) begin
                ptr_r <= shift_r[2:0];
              end
              if (byte_cnt_r != 2'h3) begin
                byte_cnt_r <= byte_cnt_r + 2'h1;
              end
            end else if (addr_match) begin
              sda_drv_r <= 1'b1;
              rw_r <= shift_r[0];
              rd_word_r <= rd_mux;
              state_r <= temp_window_pkg::S_ACK;
            end else begin
              state_r <= temp_window_pkg::S_IDLE;
            end
          end
        end
        temp_window_pkg::S_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              sda_drv_r <= ~rd_word_r[15];
              rd_word_r <= {rd_word_r[14:0], rd_word_r[15]};
              bit_cnt_r <= 4'h1;
              state_r <= temp_window_pkg::S_READ;
            end else begin
              sda_drv_r <= 1'b0;
              state_r <= temp_window_pkg::S_WRITE;
            end
          end
        end
        temp_window_pkg::S_READ: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h8) begin
              sda_drv_r <= 1'b0;
              state_r <= temp_window_pkg::S_RACK;
            end else begin
              sda_drv_r <= ~rd_word_r[15];
              rd_word_r <= {rd_word_r[14:0], rd_word_r[15]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        temp_window_pkg::S_RACK: begin
          if (scl_rise) begin
            nack_r <= sda_s_r;
          end else if (scl_fall) begin
            if (nack_r) begin
              state_r <= temp_window_pkg::S_IDLE;
            end else begin
              sda_drv_r <= ~rd_word_r[15];
              rd_word_r <= {rd_word_r[14:0], rd_word_r[15]};
              bit_cnt_r <= 4'h1;
              state_r <= temp_window_pkg::S_READ;
            end
          end
        end
        default: sda_drv_r <= 1'b0;
      endcase
    end
  end

  // Register writes stay open in shutdown; the temperature word is read only.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_r <= temp_window_pkg::CFG_RESET;
      low_r <= temp_window_pkg::LOW_RESET;
      high_r <= temp_window_pkg::HIGH_RESET;
      critical_r <= temp_window_pkg::CRITICAL_RESET;
      hysteresis_r <= temp_window_pkg::HYSTERESIS_RESET;
      msb_r <= 8'h00;
    end else if (wr_byte && byte_cnt_r != 2'h0) begin
      if (ptr_r == temp_window_pkg::PTR_CONFIG && byte_cnt_r == 2'h1) begin
        cfg_r <= shift_r[4:0];
      end else if (byte_cnt_r == 2'h1) begin
        msb_r <= shift_r;
      end else if (byte_cnt_r == 2'h2) begin
        case (ptr_r)
          temp_window_pkg::PTR_HYSTERESIS: hysteresis_r <= {msb_r, shift_r[7:3]};
          temp_window_pkg::PTR_CRITICAL: critical_r <= {msb_r, shift_r[7:3]};
          temp_window_pkg::PTR_LOW: low_r <= {msb_r, shift_r[7:3]};
          temp_window_pkg::PTR_HIGH: high_r <= {msb_r, shift_r[7:3]};
          default: msb_r <= msb_r;
        endcase
      end
    end
  end

  // Shutdown is taken at once, which is within the allowed latency.
  assign conv_run = ~cfg_r[temp_window_pkg::CFG_SHUTDOWN_BIT];
  assign conv_done = conv_run && !rd_evt && (conv_cnt_r == 32'(CONV_CYCLES - 1));

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      conv_cnt_r <= 32'h0;
      conv_done_r <= 1'b0;
      temp_r <= temp_window_pkg::TEMP_RESET;
    end else begin
      conv_done_r <= conv_done;
      if (rd_evt || !conv_run || conv_done) begin
        conv_cnt_r <= 32'h0;
      end else begin
        conv_cnt_r <= conv_cnt_r + 32'h1;
      end
      if (conv_done) begin
        temp_r <= TEMP_SAMPLE;
      end
    end
  end

  // Hysteresis points in 14 bits so that no sum or difference wraps.
  always_comb begin
    t_s = ext(TEMP_SAMPLE);
    low_h = ext(low_r) + ext(hysteresis_r);
    high_h = ext(high_r) - ext(hysteresis_r);
    critical_h = ext(critical_r) - ext(hysteresis_r);
    need = cfg_r[temp_window_pkg::CFG_FAULTQ_BIT] ? temp_window_pkg::FAULT_QUEUE_DEPTH : 3'h1;
    q_lo_nxt = qnext(q_lo_r, t_s < ext(low_r));
    q_hi_nxt = qnext(q_hi_r, t_s > ext(high_r));
    q_cr_nxt = qnext(q_cr_r, t_s > ext(critical_r));
    low_nxt = (q_lo_nxt >= need) ? 1'b1 : ((t_s > low_h) ? 1'b0 : low_flag_r);
    high_nxt = (q_hi_nxt >= need) ? 1'b1 : ((t_s < high_h) ? 1'b0 : high_flag_r);
    critical_nxt = (q_cr_nxt >= need) ? 1'b1 : ((t_s < critical_h) ? 1'b0 : critical_flag_r);
    window_event = (low_nxt != low_flag_r) || (high_nxt != high_flag_r);
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q_lo_r <= 3'h0;
      q_hi_r <= 3'h0;
      q_cr_r <= 3'h0;
      low_flag_r <= 1'b0;
      high_flag_r <= 1'b0;
      critical_flag_r <= 1'b0;
    end else if (conv_done) begin
      q_lo_r <= q_lo_nxt;
      q_hi_r <= q_hi_nxt;
      q_cr_r <= q_cr_nxt;
      low_flag_r <= low_nxt;
      high_flag_r <= high_nxt;
      critical_flag_r <= critical_nxt;
    end
  end

  // A read in the completing cycle cancels the conversion, so the clear by read wins.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      alert_r <= 1'b0;
    end else if (!conv_run) begin
      alert_r <= 1'b0;
    end else if (conv_done) begin
      if (cfg_r[temp_window_pkg::CFG_MODE_BIT]) begin
        alert_r <= alert_r | window_event;
      end else begin
        alert_r <= low_nxt | high_nxt;
      end
    end else if (rd_evt) begin
      alert_r <= 1'b0;
    end
  end

  // Open drain: the pin is pulled low whenever active level and polarity disagree.
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      alert_oe_r <= 1'b0;
      alarm_oe_r <= 1'b0;
    end else begin
      alert_oe_r <= alert_r ^ ~cfg_r[temp_window_pkg::CFG_ALERT_POL_BIT] ^ 1'b1;
      alarm_oe_r <= (critical_flag_r & conv_run) ^ cfg_r[temp_window_pkg::CFG_ALARM_POL_BIT];
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_drv_r;
  assign ALERT_OUT = 1'b0;
  assign ALERT_OE = alert_oe_r;
  assign CRITICAL_ALARM_OUT = 1'b0;
  assign CRITICAL_ALARM_OE = alarm_oe_r;
  assign CONV_DONE = conv_done_r;
  assign SHUTDOWN_ACTIVE = ~conv_run;

  read_restart_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    rd_evt |=> (conv_cnt_r == 32'h0) && !conv_done_r)
    else $error("read did not restart conversion");
  flags_stable_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !conv_done |=> $stable({low_flag_r, high_flag_r, critical_flag_r}))
    else $error("status flag moved without a conversion");
  cmp_read_clear_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    rd_evt && !cfg_r[temp_window_pkg::CFG_MODE_BIT] |=> !alert_r ##1 !alert_r || conv_done_r)
    else $error("comparator alert survived a read");
  event_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    alert_r && cfg_r[temp_window_pkg::CFG_MODE_BIT] && conv_run && !rd_evt |=> alert_r)
    else $error("event alert dropped without a read");
  low_release_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    conv_done && low_flag_r && (t_s <= low_h) |=> low_flag_r)
    else $error("low flag released inside hysteresis");
  queue_depth_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    conv_done && cfg_r[temp_window_pkg::CFG_FAULTQ_BIT] && !high_flag_r && (q_hi_r < 3'h3) |=> !high_flag_r)
    else $error("high flag set before four faults");
  single_fault_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    conv_done && !cfg_r[temp_window_pkg::CFG_FAULTQ_BIT] && (t_s > ext(critical_r)) |=> critical_flag_r)
    else $error("critical flag missed a single fault");
  shutdown_quiet_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    !conv_run |-> !conv_done ##2 (alarm_oe_r == cfg_r[temp_window_pkg::CFG_ALARM_POL_BIT]) || conv_run)
    else $error("output active during shutdown");
  addr_ignore_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
    (state_r == temp_window_pkg::S_ADDR) && scl_fall && (bit_cnt_r == 4'h8) && !addr_match |=> !SDA_OE)
    else $error("acknowledged a foreign address");

endmodule : temp_window_comparator

// File: verilog/temp_window_pkg.sv
package temp_window_pkg;
  // Clock and conversion timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_US = 100;
  localparam int CONV_CYCLES = CONV_TIME_US * 1000 / CLK_PERIOD_NS;
  // Serial bus slave address, fixed upper five bits.
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h12;
  // Register select codes held in the pointer.
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CONFIG = 3'h1;
  localparam logic [2:0] PTR_HYSTERESIS = 3'h2;
  localparam logic [2:0] PTR_CRITICAL = 3'h3;
  localparam logic [2:0] PTR_LOW = 3'h4;
  localparam logic [2:0] PTR_HIGH = 3'h5;
  localparam logic [2:0] PTR_RESET = 3'h0;
  // Configuration field positions and reset value.
  localparam int CFG_SHUTDOWN_BIT = 0;
  localparam int CFG_MODE_BIT = 1;
  localparam int CFG_ALARM_POL_BIT = 2;
  localparam int CFG_ALERT_POL_BIT = 3;
  localparam int CFG_FAULTQ_BIT = 4;
  localparam logic [4:0] CFG_RESET = 5'h00;
  // Temperature word layout: value in bits 15..3, flags below.
  localparam int TEMP_LSB_POS = 3;
  // Setpoint reset values in 0.0625 degree steps.
  localparam logic [12:0] LOW_RESET = 13'h00a0;
  localparam logic [12:0] HIGH_RESET = 13'h0400;
  localparam logic [12:0] CRITICAL_RESET = 13'h0500;
  localparam logic [12:0] HYSTERESIS_RESET = 13'h0020;
  localparam logic [12:0] TEMP_RESET = 13'h0000;
  // Consecutive faulty conversions needed with the queue enabled.
  localparam logic [2:0] FAULT_QUEUE_DEPTH = 3'h4;

  typedef enum {S_IDLE, S_ADDR, S_ACK, S_WRITE, S_READ, S_RACK} bus_state_t;
endpackage : temp_window_pkg
